/* hdl/rpc_pkg.sv */
package rpc_pkg;
   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int PC_W = 14;
   localparam logic [PC_W-1:0] PC_START   = 14'h0000;
   localparam logic [3:0]      NIB_CLR    = 4'h0;
   localparam logic [3:0]      NIB_SET    = 4'hf;
   localparam logic [3:0]      MODE_RST   = 4'hc;
   localparam logic [3:0]      SRC_RST    = 4'h8;
   localparam logic            PA_RST     = 1'b0;
   localparam int NPORT = 24;
   localparam int NLCD  = 36;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int MCLK_HZ      = 10_000_000;
   localparam int MCYC_NS      = 1000;
   localparam int MCYC_CYCLES  = (MCYC_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [3:0] MCYC_CNT = 4'(MCYC_CYCLES);

   typedef enum logic [1:0] {RPC_RUN, RPC_CLKOP, RPC_BACKUP} rpc_state_t;

   typedef struct packed {
      logic [3:0] prescCtl;
      logic [3:0] tmr1Ctl;
      logic [3:0] tmr2Ctl;
      logic [3:0] tmr3Ctl;
      logic [3:0] lcdTmrCtl;
      logic [3:0] tmrAuxCtl;
      logic [3:0] intCtl1;
      logic [3:0] intCtl2;
      logic [3:0] extIntCtl;
      logic [3:0] clkMode;
      logic [3:0] clkSrc;
      logic [3:0] lcdCtl1;
      logic [3:0] lcdCtl2;
      logic [3:0] lcdSel3;
      logic [3:0] lcdSel0;
      logic [3:0] lcdSel1;
      logic [3:0] lcdSel3b;
   } rpc_ctl_t;

   typedef struct packed {
      logic intEnable;
      logic extReq;
      logic tmr1Req;
      logic tmr2Req;
      logic tmr3Req;
      logic wdFlag1;
      logic wdFlag2;
      logic wdEnable;
   } rpc_flags_t;
endpackage : rpc_pkg

/* hdl/rpc_reset_powerdown.sv */
`timescale 1ns/1ns
// Behaviour
// [R1] any of pin, software, watchdog, power-on, supply-drop sources resets system
// [R2] after pin goes high, fetch starts at address 0 page 0
// [R3] outside circuit holds reset pin low at least one machine cycle
// [R4] at reset port pins float, latch 1, open-drain forced
// [R5] at reset shared-port pull-ups are off
// [R6] after reset and in back-up mode all LCD lines sit at top bias
// [R7] software reset instruction drives reset pin low, causing full reset
// [R8] at reset program counter clears to zero
// [R9] reset clears interrupt, powerdown, request, watchdog flags; sets watchdog enable
// [R10] reset clears prescaler, five timer and three interrupt control registers
// [R11] reset loads clock mode 1100 and clock source 1000
// [R12] reset clears two LCD controls, sets four pin selects to 1111
// [R13] detector works only while enable pin is high
// [R14] without keep-alive, detector off in power-down, back on at return
// [R15] keep-alive executed with pin high keeps detector on in power-down
// [R16] keep-alive state remembered until next system reset
// [R17] drop flag follows supply at or below skip threshold
// [R18] drop flag skip test exposes flag without clearing it
// [R19] reset below reset threshold, released at release threshold with oscillator on
// [R20] arm then clock-operating instruction enters clock operating mode
// [R21] arm then back-up instruction enters RAM back-up mode
// [R22] power-down instruction without prior arm is a no-operation
// [R23] wakeup or timer 3 underflow gives warm start with powerdown flag 1; code wakes back-up mode on a key only
// [R24] any reset source gives cold start with powerdown flag 0
// [R25] powerdown flag skip test exposes the flag for start identification
// [R26] after return timer 3 flag tells timer wake from key wake
// [R27] entering power-down with timer 3 flag set wakes immediately; code does this in clock operating mode only, back-up waits for a key
module rpc_reset_powerdown (
   input  wire logic                         mclk,            // system clock
   input  wire logic                         rst,             // async reset, power-on
   input  wire logic                         resetPinN,       // reset pin level, active low
   output logic                              resetPinDrvN,    // drives reset pin low
   output logic                              resetPinOe,      // reset pin output enable
   input  wire logic                         watchdogReset,   // watchdog reset request
   input  wire logic                         belowResetLvl,   // supply at/below reset level
   input  wire logic                         aboveReleaseLvl, // supply at/above release level
   input  wire logic                         belowSkipLvl,    // supply at/below skip level
   input  wire logic                         detectorEnPin,   // detector enable pin
   input  wire logic                         softwareResetInstr, // reset instruction
   input  wire logic                         keepaliveInstr,  // detector keep-alive instr
   input  wire logic                         powerdownArmInstr,  // arm instruction
   input  wire logic                         clockOpEntryInstr,  // clock operating entry
   input  wire logic                         backupEntryInstr,   // back-up entry
   input  wire logic                         dropFlagSkipTest,   // drop flag test instr
   input  wire logic                         pdFlagSkipTest,     // powerdown flag test instr
   input  wire logic                         wakeupKey,       // external wakeup, sync'd
   input  wire logic                         timer3Underflow, // timer 3 underflow pulse
   input  wire logic                         timer3FlagClr,   // software clears timer 3 flag
   output logic                              sysReset,        // internal system reset
   output logic                              coldStart,       // one-cycle cold start
   output logic                              warmStart,       // one-cycle warm start
   output logic [rpc_pkg::PC_W-1:0]          pcLoad,          // program counter value
   output logic                              pcLoadEn,        // load program counter
   output logic                              skipNext,        // skip next instruction
   output logic                              supplyDropFlag,  // drop flag
   output logic                              powerdownFlag,   // warm/cold indicator
   output logic                              detectorActive,  // detector enabled
   output logic                              oscEnable,       // oscillator enabled
   output rpc_pkg::rpc_state_t               pdState,         // run or power-down mode
   output logic                              subClkKeep,      // clock-op domain kept alive
   output rpc_pkg::rpc_ctl_t                 ctlRegs,         // reset values of controls
   output rpc_pkg::rpc_flags_t               flags,           // interrupt/watchdog flags
   output logic [rpc_pkg::NPORT-1:0]         portLatch,       // port output latches
   output logic [rpc_pkg::NPORT-1:0]         portOe,          // port drive enables
   output logic [rpc_pkg::NPORT-1:0]         portOpenDrain,   // open-drain forced
   output logic [rpc_pkg::NPORT-1:0]         portPullup,      // shared-port pull-ups
   output logic                              lcdAllTopBias    // all LCD lines at top bias
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] pinSync_ff, enSync_ff, rstLvlSync_ff, relSync_ff, skipSync_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinSync_ff    <= 2'h3;
         enSync_ff     <= 2'h0;
         rstLvlSync_ff <= 2'h0;
         relSync_ff    <= 2'h0;
         skipSync_ff   <= 2'h0;
      end else begin
         pinSync_ff    <= {pinSync_ff[0], resetPinN};
         enSync_ff     <= {enSync_ff[0], detectorEnPin};
         rstLvlSync_ff <= {rstLvlSync_ff[0], belowResetLvl};
         relSync_ff    <= {relSync_ff[0], aboveReleaseLvl};
         skipSync_ff   <= {skipSync_ff[0], belowSkipLvl};
      end
   end
   wire pinLow  = ~pinSync_ff[1];
   wire enHigh  = enSync_ff[1];

   // ------------------------------------------------------------
   // detector enable
   // ------------------------------------------------------------
   logic keepalive_ff;
   wire  inPd = (pdState != rpc_pkg::RPC_RUN);
   assign detectorActive = enHigh & (~inPd | keepalive_ff); // [R13] [R14] [R15]

   // supply-drop reset held until release level reached
   logic dropReset_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dropReset_ff <= 1'b0;
      end else if (detectorActive && rstLvlSync_ff[1]) begin
         dropReset_ff <= 1'b1; // [R19]
      end else if (relSync_ff[1]) begin
         dropReset_ff <= 1'b0; // [R19]
      end
   end

   // ------------------------------------------------------------
   // software reset drives the pin for one machine cycle
   // ------------------------------------------------------------
   logic [3:0] swCnt_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         swCnt_ff <= 4'h0;
      end else if (softwareResetInstr && swCnt_ff == 4'h0 && !sysReset) begin
         swCnt_ff <= rpc_pkg::MCYC_CNT; // [R7]
      end else if (swCnt_ff != 4'h0) begin
         swCnt_ff <= swCnt_ff - 4'h1;
      end
   end
   // drive lasts one machine cycle, long enough to reach the synchroniser
   assign resetPinOe   = (swCnt_ff != 4'h0); // [R7]
   assign resetPinDrvN = 1'b0;

   // ------------------------------------------------------------
   // system reset
   // ------------------------------------------------------------
   // pin sampled after synchroniser; external hold of one machine cycle assumed [R3]
   assign sysReset = rst | pinLow | watchdogReset | dropReset_ff
                   | resetPinOe; // [R1]
   assign oscEnable = ~dropReset_ff; // [R19]

   logic sysResetDly_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sysResetDly_ff <= 1'b1;
      end else begin
         sysResetDly_ff <= sysReset;
      end
   end
   assign coldStart = sysResetDly_ff & ~sysReset; // [R2] [R24]

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         keepalive_ff <= 1'b0;
      end else if (sysReset) begin
         keepalive_ff <= 1'b0; // [R16]
      end else if (keepaliveInstr && enHigh) begin
         keepalive_ff <= 1'b1; // [R15] [R16]
      end
   end

   // ------------------------------------------------------------
   // supply drop flag
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         supplyDropFlag <= 1'b0;
      end else if (sysReset || !detectorActive) begin
         supplyDropFlag <= 1'b0;
      end else begin
         supplyDropFlag <= skipSync_ff[1]; // [R17]
      end
   end

   // ------------------------------------------------------------
   // power-down sequencing
   // ------------------------------------------------------------
   logic armed_ff;
   logic tmr3Flag_ff;
   rpc_pkg::rpc_state_t nxt_state;
   wire wakeCond = wakeupKey | timer3Underflow | tmr3Flag_ff; // [R23] [R27]

   always_comb begin
      nxt_state = pdState;
      case (pdState)
         rpc_pkg::RPC_RUN: begin
            if (armed_ff && clockOpEntryInstr) begin
               nxt_state = rpc_pkg::RPC_CLKOP; // [R20]
            end else if (armed_ff && backupEntryInstr) begin
               nxt_state = rpc_pkg::RPC_BACKUP; // [R21]
            end
         end
         rpc_pkg::RPC_CLKOP: begin
            if (wakeCond) begin
               nxt_state = rpc_pkg::RPC_RUN; // [R23] [R27]
            end
         end
         rpc_pkg::RPC_BACKUP: begin
            // sub-clock domain off (subClkKeep low), so only a key can wake this mode
            if (wakeupKey) begin
               nxt_state = rpc_pkg::RPC_RUN; // [R23]
            end
         end
         default: nxt_state = rpc_pkg::RPC_RUN;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pdState <= rpc_pkg::RPC_RUN;
      end else if (sysReset) begin
         pdState <= rpc_pkg::RPC_RUN;
      end else begin
         pdState <= nxt_state;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         armed_ff <= 1'b0;
      end else if (sysReset || inPd) begin
         armed_ff <= 1'b0;
      end else if (powerdownArmInstr) begin
         armed_ff <= 1'b1;
      end else if (clockOpEntryInstr || backupEntryInstr) begin
         armed_ff <= 1'b0; // [R22]
      end
   end

   assign warmStart  = inPd & (nxt_state == rpc_pkg::RPC_RUN) & ~sysReset; // [R23]
   assign subClkKeep = (pdState != rpc_pkg::RPC_BACKUP); // [R20]

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         powerdownFlag <= 1'b0;
      end else if (sysReset) begin
         powerdownFlag <= 1'b0; // [R9] [R24]
      end else if (warmStart) begin
         powerdownFlag <= 1'b1; // [R23]
      end
   end

   // set wins over clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tmr3Flag_ff <= 1'b0;
      end else if (sysReset) begin
         tmr3Flag_ff <= 1'b0; // [R9]
      end else if (timer3Underflow && pdState != rpc_pkg::RPC_BACKUP) begin
         tmr3Flag_ff <= 1'b1; // [R26]
      end else if (timer3FlagClr) begin
         tmr3Flag_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // restart vector and skip tests
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pcLoad   <= rpc_pkg::PC_START;
         pcLoadEn <= 1'b1;
      end else begin
         pcLoad   <= rpc_pkg::PC_START; // [R8]
         pcLoadEn <= sysReset | warmStart; // [R2] [R23]
      end
   end

   // flags only read here, never cleared by the tests
   assign skipNext = (dropFlagSkipTest & supplyDropFlag)   // [R18]
                   | (pdFlagSkipTest & powerdownFlag);    // [R25]

   // ------------------------------------------------------------
   // reset states of controls, flags, ports and LCD
   // ------------------------------------------------------------
   always_comb begin
      ctlRegs           = '0;
      ctlRegs.prescCtl  = {3'h0, rpc_pkg::PA_RST};          // [R10]
      ctlRegs.tmr1Ctl   = rpc_pkg::NIB_CLR;                 // [R10]
      ctlRegs.tmr2Ctl   = rpc_pkg::NIB_CLR;
      ctlRegs.tmr3Ctl   = rpc_pkg::NIB_CLR;
      ctlRegs.lcdTmrCtl = rpc_pkg::NIB_CLR;
      ctlRegs.tmrAuxCtl = rpc_pkg::NIB_CLR;
      ctlRegs.intCtl1   = rpc_pkg::NIB_CLR;
      ctlRegs.intCtl2   = rpc_pkg::NIB_CLR;
      ctlRegs.extIntCtl = rpc_pkg::NIB_CLR;
      ctlRegs.clkMode   = rpc_pkg::MODE_RST;                // [R11]
      ctlRegs.clkSrc    = rpc_pkg::SRC_RST;                 // [R11]
      ctlRegs.lcdCtl1   = rpc_pkg::NIB_CLR;                 // [R12]
      ctlRegs.lcdCtl2   = rpc_pkg::NIB_CLR;
      ctlRegs.lcdSel3   = rpc_pkg::NIB_SET;                 // [R12]
      ctlRegs.lcdSel0   = rpc_pkg::NIB_SET;
      ctlRegs.lcdSel1   = rpc_pkg::NIB_SET;
      ctlRegs.lcdSel3b  = rpc_pkg::NIB_SET;
   end

   always_comb begin
      flags           = '0; // [R9]
      flags.wdEnable  = 1'b1; // [R9]
      flags.tmr3Req   = tmr3Flag_ff;
   end

   // outputs meant to be consumed by the port block while sysReset is high
   assign portLatch     = '1;                          // [R4]
   assign portOe        = '0;                          // [R4]
   assign portOpenDrain = {rpc_pkg::NPORT{sysReset}};  // [R4]
   assign portPullup    = '0;                          // [R5]
   assign lcdAllTopBias = sysReset | sysResetDly_ff
                        | (pdState == rpc_pkg::RPC_BACKUP); // [R6]

endmodule : rpc_reset_powerdown

/* dv/rpc_far_side.sv */
`timescale 1ns/1ns
module rpc_far_side (
   input  wire logic       holdLow,         // outside circuit pulls pin low
   input  wire logic [1:0] supplyBand,      // 0 reset,1 hysteresis,2 dip,3 normal
   input  wire logic       keyPress,        // key held down
   input  wire logic       resetPinOe,      // device drives pin
   input  wire logic       resetPinDrvN,    // device pin value
   output logic            resetPinN,       // resolved pin level
   output logic            belowResetLvl,   // supply at/below reset level
   output logic            aboveReleaseLvl, // supply at/above release level
   output logic            belowSkipLvl,    // supply at/below skip level
   output logic            wakeupKey        // key wakeup
);
   // pin has a pull-up, so released means high; bench holds it 10 clocks
   assign resetPinN       = !holdLow && !(resetPinOe && !resetPinDrvN);
   assign belowResetLvl   = (supplyBand == 2'h0);
   assign aboveReleaseLvl = (supplyBand >= 2'h2);
   assign belowSkipLvl    = (supplyBand <= 2'h2);
   assign wakeupKey       = keyPress;
endmodule : rpc_far_side

/* dv/rpc_reset_powerdown_sva.sv */
`timescale 1ns/1ns
module rpc_reset_powerdown_sva (
   input wire logic                     mclk,               // clock
   input wire logic                     rst,                // async reset
   input wire logic                     resetPinN,          // pin level
   input wire logic                     resetPinDrvN,       // pin drive
   input wire logic                     resetPinOe,         // pin enable
   input wire logic                     watchdogReset,      // watchdog
   input wire logic                     belowResetLvl,      // supply low
   input wire logic                     belowSkipLvl,       // supply dip
   input wire logic                     detectorEnPin,      // detector pin
   input wire logic                     softwareResetInstr, // instr
   input wire logic                     keepaliveInstr,     // instr
   input wire logic                     powerdownArmInstr,  // instr
   input wire logic                     clockOpEntryInstr,  // instr
   input wire logic                     backupEntryInstr,   // instr
   input wire logic                     dropFlagSkipTest,   // instr
   input wire logic                     pdFlagSkipTest,     // instr
   input wire logic                     sysReset,           // reset out
   input wire logic                     coldStart,          // cold pulse
   input wire logic                     warmStart,          // warm pulse
   input wire logic [rpc_pkg::PC_W-1:0] pcLoad,             // pc value
   input wire logic                     pcLoadEn,           // pc load
   input wire logic                     skipNext,           // skip
   input wire logic                     supplyDropFlag,     // drop flag
   input wire logic                     powerdownFlag,      // warm flag
   input wire logic                     detectorActive,     // detector on
   input wire logic                     oscEnable,          // oscillator
   input wire rpc_pkg::rpc_state_t      pdState,            // mode
   input wire rpc_pkg::rpc_flags_t      flags,              // flags
   input wire logic [rpc_pkg::NPORT-1:0] portOpenDrain,     // open-drain
   input wire logic                     lcdAllTopBias       // lcd off
);
   logic armed_ff;
   logic keep_ff;
   // ----
   // helper state: entries do not need the arm on the cycle before
   // ----
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         armed_ff <= 1'b0;
         keep_ff  <= 1'b0;
      end else begin
         armed_ff <= !sysReset && (powerdownArmInstr ||
                     (armed_ff && !clockOpEntryInstr && !backupEntryInstr));
         keep_ff  <= !sysReset && (keepaliveInstr || keep_ff);
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence swHoldS;
      (resetPinOe && !resetPinDrvN && sysReset)[*8];
   endsequence
   sequence entryS(logic instr);
      armed_ff && instr && !sysReset && pdState == rpc_pkg::RPC_RUN;
   endsequence
   pin_reset_a: assert property ((!resetPinN)[*3] |-> sysReset)
      else $error("reset pin low but no system reset");
   wdog_reset_a: assert property (watchdogReset |-> sysReset)
      else $error("watchdog without system reset");
   sw_reset_a: assert property (softwareResetInstr && !sysReset |=> swHoldS)
      else $error("software reset did not hold pin low");
   supply_reset_a: assert property ((belowResetLvl && detectorActive)[*5] |-> sysReset && !oscEnable)
      else $error("supply below reset level without reset");
   reset_state_a: assert property (sysReset && $past(sysReset) |-> flags == 8'h01 && lcdAllTopBias && portOpenDrain == '1)
      else $error("reset state wrong");
   cold_start_a: assert property ($fell(sysReset) |-> coldStart && !powerdownFlag && pcLoad == rpc_pkg::PC_START)
      else $error("cold start wrong");
   clkop_entry_a: assert property (entryS(clockOpEntryInstr) |=> pdState == rpc_pkg::RPC_CLKOP)
      else $error("armed entry did not reach clock operating");
   backup_entry_a: assert property (entryS(backupEntryInstr) |=> pdState == rpc_pkg::RPC_BACKUP)
      else $error("armed entry did not reach back-up");
   unarmed_nop_a: assert property (!armed_ff && (clockOpEntryInstr || backupEntryInstr) && !sysReset && pdState == rpc_pkg::RPC_RUN |=> pdState == rpc_pkg::RPC_RUN)
      else $error("unarmed entry left run");
   warm_start_a: assert property (warmStart |=> pdState == rpc_pkg::RPC_RUN && powerdownFlag && pcLoadEn && pcLoad == rpc_pkg::PC_START)
      else $error("warm start wrong");
   skip_test_a: assert property ((dropFlagSkipTest || pdFlagSkipTest) && !sysReset |-> skipNext == (dropFlagSkipTest ? supplyDropFlag : powerdownFlag))
      else $error("skip does not follow flag");
   drop_flag_a: assert property ((belowSkipLvl && detectorActive && !sysReset)[*5] |-> supplyDropFlag)
      else $error("drop flag not set");
   detector_pin_a: assert property ((!detectorEnPin)[*6] |-> !detectorActive && !supplyDropFlag)
      else $error("detector active with pin low");
   pd_detector_a: assert property (pdState != rpc_pkg::RPC_RUN && !keep_ff |-> !detectorActive)
      else $error("detector active in power-down");
endmodule : rpc_reset_powerdown_sva
bind rpc_reset_powerdown rpc_reset_powerdown_sva rpc_reset_powerdown_sva_inst (.*);

/* dv/tb.sv */
`timescale 1ns/1ns
module tb;
   localparam int SW = 0, KEEP = 1, ARM = 2, CLKOP = 3, BACKUP = 4, DTEST = 5, PTEST = 6;
   localparam int T3UF = 7, T3CLR = 8, KEY = 9, WDOG = 10;
   logic        mclk, rst, holdLow, detectorEnPin, lastSkip, subClkKeep;
   logic [10:0] stim;
   logic [1:0]  supplyBand;
   int          errTotal, compares, cycles;
   logic        resetPinN, resetPinDrvN, resetPinOe, belowResetLvl, aboveReleaseLvl;
   logic        belowSkipLvl, wakeupKey, sysReset, coldStart, warmStart, pcLoadEn, skipNext;
   logic        supplyDropFlag, powerdownFlag, detectorActive, oscEnable, lcdAllTopBias;
   logic [rpc_pkg::PC_W-1:0]  pcLoad;
   logic [rpc_pkg::NPORT-1:0] portLatch, portOe, portOpenDrain, portPullup;
   rpc_pkg::rpc_state_t       pdState;
   rpc_pkg::rpc_ctl_t         ctlRegs;
   rpc_pkg::rpc_flags_t       flags;
   rpc_far_side rpc_far_side_inst (.holdLow(holdLow), .supplyBand(supplyBand),
      .keyPress(stim[KEY]), .resetPinOe(resetPinOe), .resetPinDrvN(resetPinDrvN),
      .resetPinN(resetPinN), .belowResetLvl(belowResetLvl), .aboveReleaseLvl(aboveReleaseLvl),
      .belowSkipLvl(belowSkipLvl), .wakeupKey(wakeupKey));
   rpc_reset_powerdown rpc_reset_powerdown_inst (
      .mclk(mclk), .rst(rst), .resetPinN(resetPinN), .resetPinDrvN(resetPinDrvN),
      .resetPinOe(resetPinOe), .watchdogReset(stim[WDOG]), .belowResetLvl(belowResetLvl),
      .aboveReleaseLvl(aboveReleaseLvl), .belowSkipLvl(belowSkipLvl),
      .detectorEnPin(detectorEnPin), .softwareResetInstr(stim[SW]), .keepaliveInstr(stim[KEEP]),
      .powerdownArmInstr(stim[ARM]), .clockOpEntryInstr(stim[CLKOP]),
      .backupEntryInstr(stim[BACKUP]), .dropFlagSkipTest(stim[DTEST]),
      .pdFlagSkipTest(stim[PTEST]), .wakeupKey(wakeupKey), .timer3Underflow(stim[T3UF]),
      .timer3FlagClr(stim[T3CLR]), .sysReset(sysReset), .coldStart(coldStart),
      .warmStart(warmStart), .pcLoad(pcLoad), .pcLoadEn(pcLoadEn), .skipNext(skipNext),
      .supplyDropFlag(supplyDropFlag), .powerdownFlag(powerdownFlag),
      .detectorActive(detectorActive), .oscEnable(oscEnable), .pdState(pdState),
      .subClkKeep(subClkKeep), .ctlRegs(ctlRegs), .flags(flags), .portLatch(portLatch),
      .portOe(portOe), .portOpenDrain(portOpenDrain), .portPullup(portPullup),
      .lcdAllTopBias(lcdAllTopBias));
   // ----
   // access tasks
   // ----
   task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errTotal++;
         $display("wrong value at %0t ns: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   // skip result is combinational, so it is caught while the pulse stands
   task automatic pulse(input int b);
      @(negedge mclk);
      stim[b] = 1'b1;
      #10 lastSkip = skipNext;
      @(negedge mclk);
      stim[b] = 1'b0;
   endtask : pulse
   task automatic printVerdict;
      $display("compares %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : printVerdict
   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         errTotal++;
         printVerdict();
      end
   end
   initial begin
      mclk = 1'b0; rst = 1'b1; stim = '0; holdLow = 1'b0; supplyBand = 2'h3;
      detectorEnPin = 1'b1; lastSkip = 1'b0; errTotal = 0; compares = 0; cycles = 0;
      cyc(12);
      chk(ctlRegs, 68'h0_0000_0000_c800_ffff, "control regs");
      chk(flags, 8'h01, "flags");
      chk({portLatch, portOe, portOpenDrain, portPullup}, {24'hff_ffff, 24'h0, 24'hff_ffff, 24'h0}, "ports");
      chk({lcdAllTopBias, pcLoad}, {1'b1, rpc_pkg::PC_START}, "lcd and pc");
      rst = 1'b0;
      cyc(4);
      chk({sysReset, powerdownFlag, pcLoad}, 16'h0, "cold start");
      $display("test power_on finished");
      pulse(CLKOP); pulse(BACKUP); cyc(1);
      chk(pdState, rpc_pkg::RPC_RUN, "unarmed entry");
      $display("test unarmed finished");
      pulse(ARM); pulse(DTEST); pulse(CLKOP);
      chk({pdState, detectorActive}, {rpc_pkg::RPC_CLKOP, 1'b0}, "clock op entry");
      chk(subClkKeep, 1'b1, "sub-clock on");
      pulse(T3UF);
      chk({pdState, powerdownFlag, flags.tmr3Req, detectorActive}, {rpc_pkg::RPC_RUN, 3'b111}, "timer wake");
      pulse(PTEST);
      chk(lastSkip, 1'b1, "warm start seen");
      pulse(ARM); pulse(CLKOP); cyc(2);
      chk({pdState, powerdownFlag}, {rpc_pkg::RPC_RUN, 1'b1}, "pending wake");
      pulse(T3CLR);
      chk(flags.tmr3Req, 1'b0, "timer flag clear");
      $display("test clock_op finished");
      pulse(KEEP); pulse(ARM); pulse(BACKUP);
      chk({pdState, detectorActive, lcdAllTopBias}, {rpc_pkg::RPC_BACKUP, 2'b11}, "backup entry");
      chk(subClkKeep, 1'b0, "sub-clock off");
      pulse(KEY);
      chk({pdState, flags.tmr3Req, powerdownFlag}, {rpc_pkg::RPC_RUN, 2'b01}, "key wake");
      $display("test backup finished");
      supplyBand = 2'h2; cyc(6); pulse(DTEST);
      chk({supplyDropFlag, lastSkip}, 2'b11, "drop flag set");
      supplyBand = 2'h3; cyc(6);
      chk(supplyDropFlag, 1'b0, "drop flag clear");
      detectorEnPin = 1'b0; supplyBand = 2'h0; cyc(8);
      chk({detectorActive, supplyDropFlag, sysReset}, 3'b000, "detector off");
      detectorEnPin = 1'b1; cyc(6);
      chk({sysReset, oscEnable}, 2'b10, "supply reset");
      supplyBand = 2'h1; cyc(6);
      chk(sysReset, 1'b1, "hysteresis");
      supplyBand = 2'h3; cyc(8);
      chk({sysReset, oscEnable, powerdownFlag}, 3'b010, "supply release");
      pulse(ARM); pulse(CLKOP);
      chk(detectorActive, 1'b0, "keep-alive forgotten");
      pulse(KEY);
      $display("test supply finished");
      pulse(SW);
      chk({resetPinOe, resetPinN, sysReset}, 3'b101, "software reset");
      cyc(16);
      chk({sysReset, powerdownFlag}, 2'b00, "software release");
      stim[WDOG] = 1'b1; cyc(2);
      chk(sysReset, 1'b1, "watchdog reset");
      stim[WDOG] = 1'b0; cyc(4);
      holdLow = 1'b1; cyc(10);
      chk(sysReset, 1'b1, "pin reset");
      holdLow = 1'b0; cyc(4);
      chk({sysReset, pcLoad}, 15'h0, "pin release");
      $display("test resets finished");
      printVerdict();
   end
endmodule : tb
